// ==== serial_partner.sv ====
/*
  Far-side serial device: shifts queued bits out on each rising clock edge,
  and in slave mode makes a 200 ns clock for the number of bits it is asked for.
  Assumes the bench resolves both lines from all drivers.
*/
`timescale 1ns/1ps
module serial_partner (
  // Resolved lines
  input wire logic ck_line,
  input wire logic dt_line,
  // Own drive
  output logic ck_drv,
  output logic dt_drv
);
  logic q[$];
  logic [15:0] got = 16'h0000;
  initial ck_drv = 1'b0;
  initial dt_drv = 1'b0;
  task automatic load(input logic [8:0] w, input int n);
    for (int i = 0; i < n; i++) q.push_back(w[i]);
  endtask : load
  // With nothing queued the line flips, so a stale bit is never mistaken for data.
  always @(posedge ck_line) begin
    if (q.size() > 0) dt_drv <= q.pop_front();
    else dt_drv <= ~dt_drv;
  end
  // Samples late in the low phase, well after the port's synchronised edge.
  // Edges are kept off the port's clock edges, so the port never samples a moving pin.
  task automatic clk_bits(input int n);
    #5;
    repeat (n) begin
      ck_drv = 1'b1;
      #100;
      ck_drv = 1'b0;
      #90;
      got = {dt_line, got[15:1]};
      #10;
    end
  endtask : clk_bits
endmodule : serial_partner

// ==== sync_serial_checker.sv ====
/*
  Checker for the serial port: bus handshakes, pin ownership and wake ports.
  Assumes one aclk domain with synchronous active-low reset; attached by bind.
*/
`timescale 1ns/1ps
module sync_serial_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core and pins
  input wire logic core_sleep,
  input wire logic core_wake,
  input wire logic irq_vector_req,
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe,
  input wire logic serial_data_pin_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_wr_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read response late");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_ar_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while busy");
  property p_excl;
    !(serial_clock_pin_oe && serial_data_pin_oe);
  endproperty
  a_excl: assert property (p_excl) else $error("clock and data driven together");
  property p_vector;
    irq_vector_req |-> core_wake;
  endproperty
  a_vector: assert property (p_vector) else $error("vector without wake");
  // Divisor is at most 0xff, so the first rising edge is due within 256 cycles.
  property p_clk_start;
    $rose(serial_clock_pin_oe) |-> ##[1:300] $rose(serial_clock_pin_out);
  endproperty
  a_clk_start: assert property (p_clk_start) else $error("shift clock idle");
  property p_sleep_tx;
    core_sleep && serial_data_pin_oe |=> serial_data_pin_oe;
  endproperty
  a_sleep_tx: assert property (p_sleep_tx) else $error("sleep stopped transmit");
endmodule : sync_serial_checker

bind sync_serial_port sync_serial_checker i_sync_serial_checker (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .core_sleep(core_sleep), .core_wake(core_wake), .irq_vector_req(irq_vector_req),
  .serial_clock_pin_out(serial_clock_pin_out), .serial_clock_pin_oe(serial_clock_pin_oe),
  .serial_data_pin_oe(serial_data_pin_oe)
);

// ==== sync_serial_pkg.sv ====
/*
  Constants for the synchronous serial port: register indices, field bits, reset values.
  Assumes a 32-bit AXI4-Lite slave where byte address = 4 * register index.
*/
// Behaviour
// - Reception starts when single-word or continuous enable is set in sync mode; in slave mode the code starts it on continuous enable only.
// - Data line is sampled on the falling shift clock edge.
// - Single-word enable alone receives one word, then clears itself.
// - Continuous enable receives words back to back until cleared.
// - Both enables set behaves as continuous reception.
// - Finished word moves from shift register to receive buffer if room.
// - Receive flag sets on transfer; wake only when its enable is set.
// - Receive flag is read-only and clears when buffer reads leave it empty.
// - Receive buffer is a two-entry FIFO read twice to empty.
// - Last bit of third word with full buffer sets overrun and drops it.
// - Overrun clears only by clearing continuous enable; software must do so.
// - Overrun blocks every transfer into the receive buffer.
// - Ninth bit travels with each FIFO entry; reads show the next one.
// - Clock source clear selects slave mode using the external clock pin.
// - Slave mode keeps shifting during core sleep on the external clock.
// - First of two written words moves at once; second waits, flag clear.
// - After first word shifts out, second loads and transmit flag sets.
// - Transmit flag with its enable wakes core; global and peripheral enables request vector.
package sync_serial_pkg;
  localparam logic [7:0] IDX_CORE_IRQ = 8'h0b;
  localparam logic [7:0] IDX_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_RX_STAT = 8'h18;
  localparam logic [7:0] IDX_TX_BUF = 8'h19;
  localparam logic [7:0] IDX_RX_BUF = 8'h1a;
  localparam logic [7:0] IDX_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_TX_STAT = 8'h98;
  localparam logic [7:0] IDX_BAUD = 8'h99;
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_EN_BIT = 6;
  localparam int RX_FLAG_BIT = 5;
  localparam int TX_FLAG_BIT = 4;
  localparam int PORT_EN_BIT = 7;
  localparam int RX9_SEL_BIT = 6;
  localparam int SINGLE_EN_BIT = 5;
  localparam int CONT_EN_BIT = 4;
  localparam int OVERRUN_BIT = 1;
  localparam int CLK_SRC_BIT = 7;
  localparam int TX9_SEL_BIT = 6;
  localparam int TX_EN_BIT = 5;
  localparam int SYNC_BIT = 4;
  localparam int BRGH_BIT = 2;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] TX_STAT_RESET = 8'h02;
  localparam logic [7:0] RX_STAT_WMASK = 8'hf0;
  localparam logic [7:0] TX_STAT_WMASK = 8'hf5;
  localparam logic [7:0] FLAGS_WMASK = 8'hcf;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sync_serial_pkg

// ==== sync_serial_port.sv ====
/*
  Synchronous half-duplex serial port: master/slave reception with a two-deep
  receive FIFO, slave transmission, AXI4-Lite register access.
  Assumes the clock and data pins are resolved outside from out/oe pairs and
  that the external shift clock is much slower than aclk.
*/
`timescale 1ns/1ps
module sync_serial_port
  import sync_serial_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core power state and wake
  input wire logic core_sleep,
  output logic core_wake,
  output logic irq_vector_req,
  // Serial clock pin
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  // Serial data pin
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe
);

  if (ADDR_W < 11) begin : g_addr_check
    $error("ADDR_W must be at least 11");
  end

  // Bus slave state.
  logic aw_hold_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_hold_reg;
  logic [7:0] w_data_reg;
  logic w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;

  // Software-visible control.
  logic [7:0] core_irq_reg;
  logic [7:0] flags_other_reg;
  logic [7:0] enables_reg;
  logic [7:0] rx_stat_reg;
  logic [7:0] tx_stat_reg;
  logic [7:0] tx_buffer_reg;
  logic [7:0] baud_divisor_reg;

  // Receive path.
  logic [8:0] rx_shift_register_reg;
  logic [3:0] rx_cnt_reg;
  logic [8:0] fifo_reg [2];
  logic rd_ptr_reg;
  logic [1:0] fifo_cnt_reg;
  logic overrun_error_reg;

  // Transmit path.
  logic tx_full_reg;
  logic [8:0] tx_shift_register_reg;
  logic tx_busy_reg;
  logic [3:0] tx_cnt_reg;
  logic dt_out_reg;

  // Master clock generator and pin synchronisers.
  logic [7:0] brg_cnt_reg;
  logic mclk_reg;
  logic ck_s1_reg;
  logic ck_s2_reg;
  logic ck_s3_reg;
  logic dt_s1_reg;
  logic dt_s2_reg;

  // Bus decode.
  wire wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  wire wr_on = wr_fire & w_strb_reg;
  wire [7:0] aw_idx = aw_addr_reg[9:2];
  wire aw_low_ok = (aw_addr_reg[1:0] == 2'h0) & (aw_addr_reg[ADDR_W-1:10] == '0);
  wire wr_core_irq = wr_on & aw_low_ok & (aw_idx == IDX_CORE_IRQ);
  wire wr_flags = wr_on & aw_low_ok & (aw_idx == IDX_FLAGS);
  wire wr_rx_stat = wr_on & aw_low_ok & (aw_idx == IDX_RX_STAT);
  wire wr_tx_buf = wr_on & aw_low_ok & (aw_idx == IDX_TX_BUF);
  wire wr_enables = wr_on & aw_low_ok & (aw_idx == IDX_ENABLES);
  wire wr_tx_stat = wr_on & aw_low_ok & (aw_idx == IDX_TX_STAT);
  wire wr_baud = wr_on & aw_low_ok & (aw_idx == IDX_BAUD);
  wire wr_hit = aw_low_ok & ((aw_idx == IDX_CORE_IRQ) | (aw_idx == IDX_FLAGS)
    | (aw_idx == IDX_RX_STAT) | (aw_idx == IDX_TX_BUF) | (aw_idx == IDX_RX_BUF)
    | (aw_idx == IDX_ENABLES) | (aw_idx == IDX_TX_STAT) | (aw_idx == IDX_BAUD));
  wire [7:0] wr_byte = w_data_reg;

  wire ar_fire = s_axi_arvalid & ~rvalid_reg;
  wire [7:0] ar_idx = s_axi_araddr[9:2];
  wire ar_low_ok = (s_axi_araddr[1:0] == 2'h0)
    & (s_axi_araddr[ADDR_W-1:10] == '0);

  // Mode decode.
  wire port_on = rx_stat_reg[PORT_EN_BIT] & tx_stat_reg[SYNC_BIT];
  wire master = tx_stat_reg[CLK_SRC_BIT];
  wire cont_en = rx_stat_reg[CONT_EN_BIT];
  wire single_en = rx_stat_reg[SINGLE_EN_BIT];
  wire tx_en = tx_stat_reg[TX_EN_BIT];
  // Single-word enable means nothing in slave mode.
  wire rx_en = port_on & (cont_en | (master & single_en));
  wire [3:0] rx_bits = rx_stat_reg[RX9_SEL_BIT] ? BITS_9 : BITS_8;
  wire [3:0] tx_bits = tx_stat_reg[TX9_SEL_BIT] ? BITS_9 : BITS_8;

  // Master shift clock; stops with the core clock during sleep.
  wire brg_run = rx_en & master & ~core_sleep;
  wire brg_wrap = brg_run & (brg_cnt_reg == baud_divisor_reg);
  wire m_fall = brg_wrap & mclk_reg;

  // Edges of the synchronised external clock.
  wire s_fall = ck_s3_reg & ~ck_s2_reg;
  wire s_rise = ~ck_s3_reg & ck_s2_reg;

  // Receive sampling.
  wire rx_fall = rx_en & (master ? m_fall : s_fall);
  wire [8:0] rx_shift_next = {dt_s2_reg, rx_shift_register_reg[8:1]};
  wire [8:0] rx_word = rx_stat_reg[RX9_SEL_BIT] ? rx_shift_next
    : {1'b0, rx_shift_next[8:1]};
  wire rx_last = rx_fall & (rx_cnt_reg == rx_bits - 4'h1);
  wire fifo_full = (fifo_cnt_reg == FIFO_FULL);
  wire push = rx_last & ~fifo_full & ~overrun_error_reg;
  wire overrun_set = rx_last & fifo_full & ~overrun_error_reg;
  wire single_done = rx_last & master & ~cont_en;
  wire [8:0] fifo_head = fifo_reg[rd_ptr_reg];
  wire fifo_wr_idx = rd_ptr_reg ^ fifo_cnt_reg[0];
  wire pop = ar_fire & ar_low_ok & (ar_idx == IDX_RX_BUF)
    & (fifo_cnt_reg != 2'h0);
  wire rx_flag = (fifo_cnt_reg != 2'h0);

  // Transmit control; transmit is the slave side only.
  wire tx_ready = port_on & tx_en & ~master;
  wire tx_load = tx_ready & tx_full_reg & ~tx_busy_reg;
  // A receive enable disconnects the transmitter without resetting it.
  wire tx_drive = tx_ready & ~rx_en;
  wire tx_shift = tx_drive & s_rise & tx_busy_reg & (tx_cnt_reg != tx_bits);
  wire tx_done = tx_drive & s_fall & tx_busy_reg & (tx_cnt_reg == tx_bits);
  wire tx_flag = tx_en & ~tx_full_reg;

  // Register read view.
  wire [7:0] flags_view = (flags_other_reg & FLAGS_WMASK)
    | ({7'h0, rx_flag} << RX_FLAG_BIT) | ({7'h0, tx_flag} << TX_FLAG_BIT);
  // Status shows the head entry's ninth bit ahead of the buffer read.
  wire [7:0] rx_stat_view = (rx_stat_reg & RX_STAT_WMASK)
    | ({7'h0, overrun_error_reg} << OVERRUN_BIT) | {7'h0, fifo_head[8]};
  wire [7:0] tx_stat_view = (tx_stat_reg & TX_STAT_WMASK)
    | {6'h0, ~tx_busy_reg, 1'b0};
  logic [7:0] rd_byte;
  logic rd_hit;
  always_comb begin
    rd_hit = ar_low_ok;
    case (ar_idx)
      IDX_CORE_IRQ: rd_byte = core_irq_reg;
      IDX_FLAGS: rd_byte = flags_view;
      IDX_RX_STAT: rd_byte = rx_stat_view;
      IDX_TX_BUF: rd_byte = tx_buffer_reg;
      IDX_RX_BUF: rd_byte = fifo_head[7:0];
      IDX_ENABLES: rd_byte = enables_reg;
      IDX_TX_STAT: rd_byte = tx_stat_view;
      IDX_BAUD: rd_byte = baud_divisor_reg;
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Bus handshake outputs.
  assign s_axi_awready = ~aw_hold_reg;
  assign s_axi_wready = ~w_hold_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // Wake and vector request.
  wire rx_wake = rx_flag & enables_reg[RX_FLAG_BIT];
  wire tx_wake = tx_flag & enables_reg[TX_FLAG_BIT];
  assign core_wake = rx_wake | tx_wake;
  assign irq_vector_req = core_wake & core_irq_reg[GLOBAL_EN_BIT]
    & core_irq_reg[PERIPH_EN_BIT];

  // Pins.
  assign serial_clock_pin_out = mclk_reg;
  assign serial_clock_pin_oe = port_on & master & rx_en;
  assign serial_data_pin_out = dt_out_reg;
  assign serial_data_pin_oe = tx_drive;

  // Write address and data are captured independently, in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && !aw_hold_reg) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
    end else if (s_axi_wvalid && !w_hold_reg) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= s_axi_wdata[7:0];
      w_strb_reg <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_reg <= {24'h0, rd_byte};
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Plain read/write registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_irq_reg <= BYTE_RESET;
      flags_other_reg <= BYTE_RESET;
      enables_reg <= BYTE_RESET;
      tx_stat_reg <= TX_STAT_RESET & TX_STAT_WMASK;
      baud_divisor_reg <= BYTE_RESET;
    end else begin
      if (wr_core_irq) core_irq_reg <= wr_byte;
      if (wr_flags) flags_other_reg <= wr_byte & FLAGS_WMASK;
      if (wr_enables) enables_reg <= wr_byte;
      if (wr_tx_stat) tx_stat_reg <= wr_byte & TX_STAT_WMASK;
      if (wr_baud) baud_divisor_reg <= wr_byte;
    end
  end

  // A software write of the receive control wins over the hardware clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_stat_reg <= BYTE_RESET;
    end else if (wr_rx_stat) begin
      rx_stat_reg <= wr_byte & RX_STAT_WMASK;
    end else if (single_done) begin
      rx_stat_reg[SINGLE_EN_BIT] <= 1'b0;
    end
  end

  // Overrun is sticky until continuous enable drops; a new set wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_error_reg <= 1'b0;
    end else if (overrun_set) begin
      overrun_error_reg <= 1'b1;
    end else if (!cont_en) begin
      overrun_error_reg <= 1'b0;
    end
  end

  // Master clock: half period of divisor + 1 aclk cycles, idle low.
  always_ff @(posedge aclk) begin
    if (!aresetn || !brg_run) begin
      brg_cnt_reg <= 8'h00;
      mclk_reg <= 1'b0;
    end else if (brg_wrap) begin
      brg_cnt_reg <= 8'h00;
      mclk_reg <= ~mclk_reg;
    end else begin
      brg_cnt_reg <= brg_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ck_s1_reg <= 1'b0;
      ck_s2_reg <= 1'b0;
      ck_s3_reg <= 1'b0;
      dt_s1_reg <= 1'b0;
      dt_s2_reg <= 1'b0;
    end else begin
      ck_s1_reg <= serial_clock_pin_in;
      ck_s2_reg <= ck_s1_reg;
      ck_s3_reg <= ck_s2_reg;
      dt_s1_reg <= serial_data_pin_in;
      dt_s2_reg <= dt_s1_reg;
    end
  end

  // Receive shifter; a dropped enable abandons a partial word.
  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_en) begin
      rx_cnt_reg <= 4'h0;
      rx_shift_register_reg <= 9'h000;
    end else if (rx_last) begin
      rx_cnt_reg <= 4'h0;
      rx_shift_register_reg <= 9'h000;
    end else if (rx_fall) begin
      rx_cnt_reg <= rx_cnt_reg + 4'h1;
      rx_shift_register_reg <= rx_shift_next;
    end
  end

  // Two-entry receive FIFO; ninth bit stored beside each byte.
  for (genvar i = 0; i < 2; i++) begin : g_fifo
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        fifo_reg[i] <= 9'h000;
      end else if (push && (fifo_wr_idx == i[0])) begin
        fifo_reg[i] <= rx_word;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_ptr_reg <= 1'b0;
      fifo_cnt_reg <= 2'h0;
    end else begin
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      if (push && !pop) fifo_cnt_reg <= fifo_cnt_reg + 2'h1;
      else if (pop && !push) fifo_cnt_reg <= fifo_cnt_reg - 2'h1;
    end
  end

  // Transmit buffer; a new write wins over the hand-off to the shifter.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buffer_reg <= BYTE_RESET;
      tx_full_reg <= 1'b0;
    end else if (wr_tx_buf) begin
      tx_buffer_reg <= wr_byte;
      tx_full_reg <= 1'b1;
    end else if (tx_load) begin
      tx_full_reg <= 1'b0;
    end
  end

  // Slave transmit shifter: a bit goes out on each external rising edge and
  // the word ends at the falling edge after the last bit.
  always_ff @(posedge aclk) begin
    if (!aresetn || !tx_ready) begin
      tx_busy_reg <= 1'b0;
      tx_cnt_reg <= 4'h0;
      tx_shift_register_reg <= 9'h000;
      dt_out_reg <= 1'b0;
    end else if (tx_load) begin
      tx_busy_reg <= 1'b1;
      tx_cnt_reg <= 4'h0;
      tx_shift_register_reg <= {tx_stat_reg[0] & tx_stat_reg[TX9_SEL_BIT],
        tx_buffer_reg};
    end else if (tx_shift) begin
      dt_out_reg <= tx_shift_register_reg[0];
      tx_shift_register_reg <= {1'b0, tx_shift_register_reg[8:1]};
      tx_cnt_reg <= tx_cnt_reg + 4'h1;
    end else if (tx_done) begin
      tx_busy_reg <= 1'b0;
    end
  end

endmodule : sync_serial_port

// ==== testbench.sv ====
/*
  Self-checking bench for the serial port: AXI4-Lite register tasks and tests.
  Assumes the bind in the checker file and the far-side model on the lines.
*/
`timescale 1ns/1ps
`define chk(nm, ex, sn) \
  begin \
    compares++; \
    if ((sn) !== (ex)) begin \
      fails++; \
      $display("wrong value %s expected %h seen %h", nm, ex, sn); \
    end \
  end
module testbench;
  import sync_serial_pkg::*;
  logic aclk, aresetn, core_sleep, core_wake, irq_vector_req;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] rresp, bresp, wresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic ck_out, ck_oe, dt_out, dt_oe, ck_drv, dt_drv;
  wire logic ck_line = ck_oe ? ck_out : ck_drv;
  wire logic dt_line = dt_oe ? dt_out : dt_drv;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] idx[8] = '{IDX_CORE_IRQ, IDX_FLAGS, IDX_RX_STAT, IDX_TX_BUF, IDX_RX_BUF,
                         IDX_ENABLES, IDX_TX_STAT, IDX_BAUD};

  sync_serial_port #(.ADDR_W(12)) i_sync_serial_port (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .core_sleep(core_sleep), .core_wake(core_wake), .irq_vector_req(irq_vector_req),
    .serial_clock_pin_in(ck_line), .serial_clock_pin_out(ck_out), .serial_clock_pin_oe(ck_oe),
    .serial_data_pin_in(dt_line), .serial_data_pin_out(dt_out), .serial_data_pin_oe(dt_oe)
  );
  serial_partner i_serial_partner (
    .ck_line(ck_line), .dt_line(dt_line), .ck_drv(ck_drv), .dt_drv(dt_drv)
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  // The whole run needs well under two thousand cycles; this only catches a hang.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      test_done();
    end
  end

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= {2'b00, i, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta || awready;
      tw = tw || wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!bvalid);
    wresp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  // Ready is held from the request on; one idle edge keeps calls from colliding.
  task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
    araddr <= {2'b00, i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic rchk(input logic [7:0] i, input logic [7:0] ex);
    logic [31:0] d;
    logic [1:0] r;
    rd(i, d, r);
    `chk($sformatf("reg %h", i), {24'h000000, ex}, d)
  endtask : rchk

  task automatic wait_bit(input logic [7:0] i, input int b);
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h00000000;
    while (d[b] !== 1'b1) rd(i, d, r);
  endtask : wait_bit

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready, core_sleep} = '0;
    aresetn = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 8; i++) rchk(idx[i], (idx[i] == IDX_TX_STAT) ? TX_STAT_RESET : BYTE_RESET);
    rd(8'h01, d, r);
    `chk("unmapped resp", RESP_SLVERR, r)
    wr(8'h01, 8'h55);
    `chk("unmapped write resp", RESP_SLVERR, wresp)
    wr(IDX_FLAGS, 8'hff);
    `chk("write resp", RESP_OKAY, wresp)
    rchk(IDX_FLAGS, 8'hcf);
    wr(IDX_FLAGS, 8'h00);
    // Master single-word reception with a ninth bit.
    wr(IDX_BAUD, 8'h07);
    wr(IDX_TX_STAT, 8'h90);
    wr(IDX_RX_STAT, 8'hc0);
    wr(IDX_ENABLES, 8'h20);
    i_serial_partner.load(9'h1a5, 9);
    wr(IDX_RX_STAT, 8'he0);
    wait_bit(IDX_FLAGS, 5);
    @(negedge aclk);
    `chk("wake", 1'b1, core_wake)
    @(posedge aclk);
    rchk(IDX_RX_STAT, 8'hc1);
    rchk(IDX_RX_BUF, 8'ha5);
    rchk(IDX_FLAGS, 8'h00);
    @(negedge aclk);
    `chk("clock oe", 1'b0, ck_oe)
    @(posedge aclk);
    // Continuous reception runs into overrun on the third word.
    i_serial_partner.load(9'h111, 9);
    i_serial_partner.load(9'h022, 9);
    i_serial_partner.load(9'h133, 9);
    wr(IDX_RX_STAT, 8'hf0);
    wait_bit(IDX_RX_STAT, 1);
    rchk(IDX_RX_STAT, 8'hf3);
    rchk(IDX_RX_BUF, 8'h11);
    rchk(IDX_RX_STAT, 8'hf2);
    rchk(IDX_RX_BUF, 8'h22);
    repeat (400) @(posedge aclk);
    rchk(IDX_FLAGS, 8'h00);
    wr(IDX_RX_STAT, 8'h80);
    // An emptied buffer shows the ninth bit of the stale entry at its read pointer, the first word.
    rchk(IDX_RX_STAT, 8'h81);
    // Slave transmission of two words while the core sleeps.
    wr(IDX_TX_STAT, 8'h30);
    wr(IDX_ENABLES, 8'h10);
    wr(IDX_CORE_IRQ, 8'hc0);
    core_sleep <= 1'b1;
    wr(IDX_TX_BUF, 8'h3c);
    wr(IDX_TX_BUF, 8'hc3);
    rchk(IDX_FLAGS, 8'h00);
    rchk(IDX_TX_STAT, 8'h30);
    i_serial_partner.clk_bits(8);
    @(negedge aclk);
    `chk("wake", 1'b1, core_wake)
    `chk("vector", 1'b1, irq_vector_req)
    i_serial_partner.clk_bits(8);
    `chk("sent", 16'hc33c, i_serial_partner.got)
    @(posedge aclk);
    core_sleep <= 1'b0;
    rchk(IDX_TX_STAT, 8'h32);
    // Slave reception of one word on the external clock while the core sleeps.
    wr(IDX_RX_STAT, 8'h90);
    core_sleep <= 1'b1;
    i_serial_partner.load(9'h05a, 8);
    i_serial_partner.clk_bits(8);
    rchk(IDX_FLAGS, 8'h30);
    rchk(IDX_RX_STAT, 8'h90);
    rchk(IDX_RX_BUF, 8'h5a);
    core_sleep <= 1'b0;
    rchk(IDX_FLAGS, 8'h10);
    test_done();
  end
endmodule : testbench
